//--- hdl/port0_gpio_defines.svh
// Offsets, field positions, reset values and constants for the port 0 block
// Operation
// - Mode 00 Schmitt input, 01 input with pull-up, 10 open-drain, 11 push-pull.
// - Upper mode register holds pins 7..4, pin 7 in the top two bits.
// - Lower mode register holds pins 3..0, pin 0 in the bottom two bits.
// - Edge select 00 disables the pin interrupt, 01 detects falling edges only.
// - Edge select 10 detects rising edges only.
// - Edge select 11 detects both rising and falling edges.
// - Upper edge-select register holds pins 7..4, pin 7 in bits 7 and 6.
// - Lower edge-select register holds pins 3..0, pin 3 top, pin 0 bottom.
// - All eight stored port registers reset to zero: inputs without pull-up, interrupts off.
`ifndef PORT0_GPIO_DEFINES_SVH
`define PORT0_GPIO_DEFINES_SVH

// ==========================================================================
// Register indices; byte address is four times the index
`define IDX_PIN_MODE_UPPER    12'h0e0
`define IDX_PIN_MODE_LOWER    12'h0e1
`define IDX_EDGE_SEL_UPPER    12'h0e2
`define IDX_EDGE_SEL_LOWER    12'h0e3
`define IDX_PIN_IRQ_PENDING   12'h0e4
`define IDX_IRQ_STATUS        12'h0e5
`define IDX_IRQ_MASK          12'h0e6
`define IDX_PIN_LEVEL         12'h0e7
`define IDX_PIN_DATA_OUT      12'h0e8

// ==========================================================================
// Field layout and reset values
`define PORT_PINS             8
`define FIELD_W               2
`define REG_ADDR_BITS         12
`define REG_RESET             8'h00

// ==========================================================================
// Mode and edge-select codes
`define MODE_IN               2'h0
`define MODE_IN_PULLUP        2'h1
`define MODE_OPEN_DRAIN       2'h2
`define MODE_PUSH_PULL        2'h3
`define EDGE_FALL_BIT         0
`define EDGE_RISE_BIT         1

// ==========================================================================
// AXI responses
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

//--- hdl/port0_gpio_pkg.sv
// Types shared by the port 0 block
package port0_gpio_pkg;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'h1,
      WR_RESP    = 2'h2
   } wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'h1,
      RD_DATA = 2'h2
   } rd_state_t;

endpackage

//--- hdl/pin_sync_edge.sv
// Two-flop pin synchroniser with rise and fall detection per pin
`timescale 1ns/10ps
`include "port0_gpio_defines.svh"
module pin_sync_edge #(
   parameter int W = `PORT_PINS
) (
   input  wire logic         mclk_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] fall_o
);
   if (W < 1) begin : g_w_check
      $error("W must be at least one");
   end

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] prev;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.meta = pin_i;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_o = s_q.sync;
   assign rise_o  = s_q.sync & ~s_q.prev;
   assign fall_o  = ~s_q.sync & s_q.prev;
endmodule // pin_sync_edge

//--- hdl/pin_mode_drive.sv
// Per-pin output driver decode from the two-bit mode fields
`timescale 1ns/10ps
`include "port0_gpio_defines.svh"
module pin_mode_drive #(
   parameter int W = `PORT_PINS
) (
   input  wire logic             mclk_i,
   input  wire logic             rstn_i,
   input  wire logic [2*W-1:0]   mode_i,
   input  wire logic [W-1:0]     data_i,
   output logic      [W-1:0]     pad_out_o,
   output logic      [W-1:0]     pad_oe_o,
   output logic      [W-1:0]     pad_pullup_o
);
   if (W < 1) begin : g_w_check
      $error("W must be at least one");
   end

   typedef struct packed {
      logic [W-1:0] out;
      logic [W-1:0] oe;
      logic [W-1:0] pu;
   } drv_state_t;

   drv_state_t s_q;
   drv_state_t s_d;

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < W; i++) begin
         s_d.out[i] = 1'b0;
         s_d.oe[i]  = 1'b0;
         s_d.pu[i]  = 1'b0;
         unique case (mode_i[2*i +: 2])
            `MODE_IN: begin
            end
            `MODE_IN_PULLUP: begin
               s_d.pu[i] = 1'b1;
            end
            // Open drain only ever sinks; a one releases the pin
            `MODE_OPEN_DRAIN: begin
               s_d.oe[i] = ~data_i[i];
            end
            `MODE_PUSH_PULL: begin
               s_d.oe[i]  = 1'b1;
               s_d.out[i] = data_i[i];
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pad_out_o    = s_q.out;
   assign pad_oe_o     = s_q.oe;
   assign pad_pullup_o = s_q.pu;
endmodule // pin_mode_drive

//--- hdl/port0_gpio.sv
// Port 0 GPIO with per-pin external interrupts behind an AXI4-Lite slave
`timescale 1ns/10ps
`include "port0_gpio_defines.svh"
module port0_gpio
   import port0_gpio_pkg::*;
#(
   parameter int ADDR_W = 14
) (
   input  wire logic              mclk_i,
   input  wire logic              rstn_i,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic [2:0]        s_axi_awprot_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic [2:0]        s_axi_arprot_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   // Port pins
   input  wire logic [7:0]        pad_in_i,
   output logic      [7:0]        pad_out_o,
   output logic      [7:0]        pad_oe_o,
   output logic      [7:0]        pad_pullup_o,
   // Interrupts
   output logic      [7:0]        ext_irq_line_o,
   output logic                   irq_o
);

   // ==========================================================================
   // Parameter check
   if (ADDR_W < `REG_ADDR_BITS + 2) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end

   localparam int NP = `PORT_PINS;

   // The pin ports are eight wide whatever the define says
   if (NP != 8) begin : g_pin_check
      $error("PORT_PINS does not match the eight pin ports");
   end

   // ==========================================================================
   // State
   typedef struct packed {
      wr_state_t   wr_st;
      logic        aw_got;
      logic        w_got;
      logic [11:0] widx;
      logic [7:0]  wdata;
      logic        wlane;
      logic [1:0]  bresp;
      rd_state_t   rd_st;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic [7:0]  mode_hi;
      logic [7:0]  mode_lo;
      logic [7:0]  esel_hi;
      logic [7:0]  esel_lo;
      logic [7:0]  pend;
      logic [7:0]  status;
      logic [7:0]  mask;
      logic [7:0]  dout;
   } regs_t;

   regs_t r_q;
   regs_t r_d;

   // ==========================================================================
   // Pin synchronisers and edge detection
   logic [NP-1:0] pin_level;
   logic [NP-1:0] pin_rise;
   logic [NP-1:0] pin_fall;

   pin_sync_edge #(
      .W       (NP)
   ) u_sync (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .pin_i   (pad_in_i),
      .level_o (pin_level),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
   );

   // ==========================================================================
   // Edge matching per pin
   logic [2*NP-1:0] mode_all;
   logic [2*NP-1:0] esel_all;
   logic [NP-1:0]   pin_event;

   assign mode_all = {r_q.mode_hi, r_q.mode_lo};
   assign esel_all = {r_q.esel_hi, r_q.esel_lo};

   for (genvar i = 0; i < NP; i++) begin : g_edge
      logic fall_en;
      logic rise_en;
      // Both enables set gives both-edge detection
      assign fall_en      = esel_all[2*i + `EDGE_FALL_BIT];
      assign rise_en      = esel_all[2*i + `EDGE_RISE_BIT];
      assign pin_event[i] = (fall_en & pin_fall[i]) | (rise_en & pin_rise[i]);
   end

   // ==========================================================================
   // Output drivers
   pin_mode_drive #(
      .W            (NP)
   ) u_drive (
      .mclk_i       (mclk_i),
      .rstn_i       (rstn_i),
      .mode_i       (mode_all),
      .data_i       (r_q.dout),
      .pad_out_o    (pad_out_o),
      .pad_oe_o     (pad_oe_o),
      .pad_pullup_o (pad_pullup_o)
   );

   // ==========================================================================
   // Address decode helpers
   logic [11:0] ar_idx;
   logic        ar_take;
   logic        aw_take;
   logic        w_take;
   logic        wr_commit;
   logic        wr_hit;
   logic        rd_hit;
   logic [7:0]  rd_val;
   logic        wr_en;
   logic [7:0]  pend_clr;
   logic [7:0]  stat_clr;

   // Only the low index bits decode; higher address bits alias
   assign ar_idx = s_axi_araddr_i[`REG_ADDR_BITS+1:2];

   assign aw_take   = s_axi_awvalid_i & s_axi_awready_o;
   assign w_take    = s_axi_wvalid_i & s_axi_wready_o;
   assign ar_take   = s_axi_arvalid_i & s_axi_arready_o;
   assign wr_commit = (r_q.wr_st == WR_COLLECT) & r_q.aw_got & r_q.w_got;
   assign wr_en     = wr_commit & wr_hit & r_q.wlane;

   always_comb begin
      unique case (r_q.widx)
         `IDX_PIN_MODE_UPPER,
         `IDX_PIN_MODE_LOWER,
         `IDX_EDGE_SEL_UPPER,
         `IDX_EDGE_SEL_LOWER,
         `IDX_PIN_IRQ_PENDING,
         `IDX_IRQ_STATUS,
         `IDX_IRQ_MASK,
         `IDX_PIN_LEVEL,
         `IDX_PIN_DATA_OUT: wr_hit = 1'b1;
         default:           wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      rd_hit = 1'b1;
      unique case (ar_idx)
         `IDX_PIN_MODE_UPPER:  rd_val = r_q.mode_hi;
         `IDX_PIN_MODE_LOWER:  rd_val = r_q.mode_lo;
         `IDX_EDGE_SEL_UPPER:  rd_val = r_q.esel_hi;
         `IDX_EDGE_SEL_LOWER:  rd_val = r_q.esel_lo;
         `IDX_PIN_IRQ_PENDING: rd_val = r_q.pend;
         `IDX_IRQ_STATUS:      rd_val = r_q.status;
         `IDX_IRQ_MASK:        rd_val = r_q.mask;
         `IDX_PIN_LEVEL:       rd_val = pin_level;
         `IDX_PIN_DATA_OUT:    rd_val = r_q.dout;
         default: begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Zeros written to the pending register clear; ones are ignored
   assign pend_clr = (wr_en && r_q.widx == `IDX_PIN_IRQ_PENDING) ? ~r_q.wdata : 8'h00;

   // Status clears on the read that returns it
   assign stat_clr = (ar_take && rd_hit && ar_idx == `IDX_IRQ_STATUS) ? r_q.status : 8'h00;

   // ==========================================================================
   // Next state
   always_comb begin
      r_d = r_q;

      // Write channel capture, either order
      if (aw_take) begin
         r_d.aw_got = 1'b1;
         r_d.widx   = s_axi_awaddr_i[`REG_ADDR_BITS+1:2];
      end
      if (w_take) begin
         r_d.w_got = 1'b1;
         r_d.wdata = s_axi_wdata_i[7:0];
         r_d.wlane = s_axi_wstrb_i[0];
      end

      unique case (r_q.wr_st)
         WR_COLLECT: begin
            if (wr_commit) begin
               r_d.aw_got = 1'b0;
               r_d.w_got  = 1'b0;
               r_d.bresp  = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
               r_d.wr_st  = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready_i) begin
               r_d.wr_st = WR_COLLECT;
            end
         end
      endcase

      if (wr_en) begin
         unique case (r_q.widx)
            `IDX_PIN_MODE_UPPER: r_d.mode_hi = r_q.wdata;
            `IDX_PIN_MODE_LOWER: r_d.mode_lo = r_q.wdata;
            `IDX_EDGE_SEL_UPPER: r_d.esel_hi = r_q.wdata;
            `IDX_EDGE_SEL_LOWER: r_d.esel_lo = r_q.wdata;
            `IDX_IRQ_MASK:       r_d.mask    = r_q.wdata;
            `IDX_PIN_DATA_OUT:   r_d.dout    = r_q.wdata;
            default: begin
            end
         endcase
      end

      // A new edge in the clearing cycle survives the clear
      r_d.pend   = (r_q.pend & ~pend_clr) | pin_event;
      r_d.status = (r_q.status & ~stat_clr) | pin_event;

      // Read channel
      unique case (r_q.rd_st)
         RD_IDLE: begin
            if (ar_take) begin
               r_d.rdata = rd_val;
               r_d.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
               r_d.rd_st = RD_DATA;
            end
         end
         RD_DATA: begin
            if (s_axi_rready_i) begin
               r_d.rd_st = RD_IDLE;
            end
         end
      endcase
   end

   // ==========================================================================
   // State register
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         r_q         <= '0;
         r_q.wr_st   <= WR_COLLECT;
         r_q.rd_st   <= RD_IDLE;
         r_q.mode_hi <= `REG_RESET;
         r_q.mode_lo <= `REG_RESET;
         r_q.esel_hi <= `REG_RESET;
         r_q.esel_lo <= `REG_RESET;
         r_q.pend    <= `REG_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   // ==========================================================================
   // Outputs
   assign s_axi_awready_o = (r_q.wr_st == WR_COLLECT) & ~r_q.aw_got;
   assign s_axi_wready_o  = (r_q.wr_st == WR_COLLECT) & ~r_q.w_got;
   assign s_axi_bvalid_o  = (r_q.wr_st == WR_RESP);
   assign s_axi_bresp_o   = r_q.bresp;
   assign s_axi_arready_o = (r_q.rd_st == RD_IDLE);
   assign s_axi_rvalid_o  = (r_q.rd_st == RD_DATA);
   assign s_axi_rdata_o   = {24'h000000, r_q.rdata};
   assign s_axi_rresp_o   = r_q.rresp;

   assign ext_irq_line_o = r_q.pend;
   assign irq_o          = |(r_q.status & r_q.mask);

endmodule // port0_gpio

//--- testbench/port0_gpio_chk.sv
// Concurrent checks on the port 0 block ports
`timescale 1ns/10ps
module port0_gpio_chk (
   input wire logic        mclk_i,
   input wire logic        rstn_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [7:0]  pad_in_i,
   input wire logic [7:0]  pad_oe_o,
   input wire logic [7:0]  pad_pullup_o,
   input wire logic [7:0]  ext_irq_line_o,
   input wire logic        irq_o
);
   // ==========================================================
   // Pin history, so a new pending bit can be traced to an edge
   logic [7:0] h1_q, h2_q, h3_q, h4_q, h5_q;
   logic       aw_take;
   assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
   always_ff @(posedge mclk_i) begin
      h1_q <= pad_in_i;
      h2_q <= h1_q;
      h3_q <= h2_q;
      h4_q <= h3_q;
      h5_q <= h4_q;
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   sequence wr_take;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence wr_answer;
      !s_axi_awready_o ##1 s_axi_bvalid_o;
   endsequence

   a_wr_answer: assert property (wr_take |=> wr_answer)
      else $error("write response not on the second cycle");
   a_b_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("write response held after handshake");
   a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o
      && !s_axi_arready_o) else $error("read data not one cycle after address");
   a_r_drop: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("read data held after handshake");
   a_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_reset_zero: assert property ($rose(rstn_i) |-> ext_irq_line_o == 8'h00
      && pad_oe_o == 8'h00 && pad_pullup_o == 8'h00 && !irq_o)
      else $error("outputs not cleared by reset");
   a_pull_input: assert property ((pad_pullup_o & pad_oe_o) == 8'h00)
      else $error("pull-up on a driven pin");
   a_pend_cause: assert property ((ext_irq_line_o & ~$past(ext_irq_line_o) & ~((h1_q ^ h2_q)
      | (h2_q ^ h3_q) | (h3_q ^ h4_q) | (h4_q ^ h5_q))) == 8'h00)
      else $error("pending bit set without a pin edge");
   a_pend_clear: assert property (|(~ext_irq_line_o & $past(ext_irq_line_o)) |->
      $past(aw_take) || $past(aw_take, 2) || $past(aw_take, 3) || $past(aw_take, 4))
      else $error("pending bit cleared without a write");
endmodule // port0_gpio_chk

bind port0_gpio port0_gpio_chk i_port0_gpio_chk (.*);

//--- testbench/pin_board.sv
// Board model for the eight port pins
`timescale 1ns/10ps
module pin_board (
   input  wire logic       mclk_i,
   input  wire logic [7:0] pad_out_i,
   input  wire logic [7:0] pad_oe_i,
   input  wire logic [7:0] pad_pullup_i,
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   output logic      [7:0] pad_in_o
);
   // An undriven pin without pull-up wanders so a stale level is never trusted
   logic [7:0] float_q;
   always_ff @(posedge mclk_i) begin
      float_q <= ~pad_in_o;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_in_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                       pad_pullup_i[i] ? 1'h1 : float_q[i];
      end
   end
endmodule // pin_board

//--- testbench/port0_gpio_tb.sv
// Self-checking testbench for the port 0 block
`timescale 1ns/10ps
`include "port0_gpio_defines.svh"
module port0_gpio_tb;
   logic        mclk_i = 1'h0;
   logic        rstn_i = 1'h0;
   logic [13:0] s_axi_awaddr_i = 14'h0, s_axi_araddr_i = 14'h0;
   logic [2:0]  s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
   logic [3:0]  s_axi_wstrb_i = 4'hf;
   logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
   logic        s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
   logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic        s_axi_arready_o, s_axi_rvalid_o, irq_o;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic [7:0]  pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o, ext_irq_line_o;
   logic [7:0]  ext_val = 8'h00;
   int          errors = 0, n_compared = 0;

   always #12.5 mclk_i = ~mclk_i;

   port0_gpio i_port0_gpio (.*);
   pin_board i_pin_board (.mclk_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
      .pad_pullup_i(pad_pullup_o), .ext_en_i(8'hff), .ext_val_i(ext_val), .pad_in_o(pad_in_i));

   // ==========================================================
   // Reporting and bus access
   task automatic end_of_test();
      if (errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Readies are sampled on the falling edge: settled, and unchanged until the next rise
   task automatic xfer(input logic wr, input logic [11:0] idx, input logic [7:0] d,
                       output logic [31:0] q, output logic [1:0] rs);
      logic a, w, sa, sw, sv;
      @(posedge mclk_i);
      if (wr) begin
         s_axi_awaddr_i  <= {idx, 2'h0};
         s_axi_wdata_i   <= {24'h0, d};
         s_axi_awvalid_i <= 1'h1;
         s_axi_wvalid_i  <= 1'h1;
         s_axi_bready_i  <= 1'h1;
      end else begin
         s_axi_araddr_i  <= {idx, 2'h0};
         s_axi_arvalid_i <= 1'h1;
         s_axi_rready_i  <= 1'h1;
      end
      a = 1'h0;
      w = !wr;
      sv = 1'h0;
      for (int n = 0; n < 40 && !sv; n++) begin
         @(negedge mclk_i);
         sa = wr ? s_axi_awready_o : s_axi_arready_o;
         sw = s_axi_wready_o;
         sv = wr ? s_axi_bvalid_o : s_axi_rvalid_o;
         q  = s_axi_rdata_o;
         rs = wr ? s_axi_bresp_o : s_axi_rresp_o;
         @(posedge mclk_i);
         if (sa && !a) begin
            a = 1'h1;
            s_axi_awvalid_i <= 1'h0;
            s_axi_arvalid_i <= 1'h0;
         end
         if (sw && !w) begin
            w = 1'h1;
            s_axi_wvalid_i <= 1'h0;
         end
         if (sv) begin
            s_axi_bready_i <= 1'h0;
            s_axi_rready_i <= 1'h0;
         end
      end
      if (!sv) begin
         errors++;
         end_of_test();
      end
   endtask

   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      logic [31:0] q;
      logic [1:0]  r;
      xfer(1'h1, idx, d, q, r);
      chk("bresp", 32'h0, {30'h0, r});
   endtask

   task automatic rd(input logic [11:0] idx, input logic [7:0] e);
      logic [31:0] q;
      logic [1:0]  r;
      xfer(1'h0, idx, 8'h00, q, r);
      chk("rdata", {24'h0, e}, q);
      chk("rresp", 32'h0, {30'h0, r});
   endtask

   task automatic pins(input logic [7:0] v);
      ext_val <= v;
      repeat (6) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      logic [31:0] q;
      logic [1:0]  r;
      for (logic [11:0] i = `IDX_PIN_MODE_UPPER; i <= `IDX_IRQ_MASK; i++) begin
         rd(i, `REG_RESET);
      end
      xfer(1'h0, 12'h0f0, 8'h00, q, r);
      chk("unmapped rresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
      xfer(1'h1, 12'h0f0, 8'h5a, q, r);
      chk("unmapped bresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
   endtask

   // Each half of the port gets all four modes, so field placement is checked too
   task automatic t_modes();
      wr(`IDX_PIN_DATA_OUT, 8'h55);
      wr(`IDX_PIN_MODE_UPPER, 8'he4);
      wr(`IDX_PIN_MODE_LOWER, 8'h1b);
      rd(`IDX_PIN_MODE_UPPER, 8'he4);
      rd(`IDX_PIN_MODE_LOWER, 8'h1b);
      @(negedge mclk_i);
      chk("pad_oe", 32'h83, {24'h0, pad_oe_o});
      chk("pad_out", 32'h01, {24'h0, pad_out_o & pad_oe_o});
      chk("pad_pullup", 32'h24, {24'h0, pad_pullup_o});
      wr(`IDX_PIN_DATA_OUT, 8'haa);
      @(negedge mclk_i);
      chk("pad_oe", 32'hc1, {24'h0, pad_oe_o});
      chk("pad_out", 32'h80, {24'h0, pad_out_o & pad_oe_o});
      rd(`IDX_PIN_DATA_OUT, 8'haa);
      wr(`IDX_PIN_MODE_UPPER, 8'h00);
      wr(`IDX_PIN_MODE_LOWER, 8'h00);
   endtask

   task automatic t_edges();
      wr(`IDX_EDGE_SEL_UPPER, 8'he4);
      wr(`IDX_EDGE_SEL_LOWER, 8'h1b);
      rd(`IDX_EDGE_SEL_UPPER, 8'he4);
      rd(`IDX_EDGE_SEL_LOWER, 8'h1b);
      pins(8'hff);
      chk("ext_irq_line rise", 32'hc3, {24'h0, ext_irq_line_o});
      rd(`IDX_PIN_LEVEL, 8'hff);
      rd(`IDX_PIN_IRQ_PENDING, 8'hc3);
      wr(`IDX_PIN_IRQ_PENDING, 8'hff);
      rd(`IDX_PIN_IRQ_PENDING, 8'hc3);
      wr(`IDX_PIN_IRQ_PENDING, 8'hc2);
      rd(`IDX_PIN_IRQ_PENDING, 8'hc2);
      wr(`IDX_PIN_IRQ_PENDING, 8'h00);
      pins(8'h00);
      chk("ext_irq_line fall", 32'ha5, {24'h0, ext_irq_line_o});
      rd(`IDX_PIN_LEVEL, 8'h00);
      wr(`IDX_PIN_IRQ_PENDING, 8'h00);
   endtask

   task automatic t_irq();
      rd(`IDX_IRQ_STATUS, 8'he7);
      rd(`IDX_IRQ_STATUS, 8'h00);
      wr(`IDX_IRQ_MASK, 8'h01);
      pins(8'hff);
      chk("irq unmasked", 32'h1, {31'h0, irq_o});
      wr(`IDX_IRQ_MASK, 8'h00);
      @(negedge mclk_i);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      wr(`IDX_IRQ_MASK, 8'h01);
      rd(`IDX_IRQ_MASK, 8'h01);
      rd(`IDX_IRQ_STATUS, 8'hc3);
      @(negedge mclk_i);
      chk("irq after status read", 32'h0, {31'h0, irq_o});
   endtask

   // Reset again over live values: a driven pin, pending bits and a set mask bit
   task automatic t_rerun();
      wr(`IDX_PIN_MODE_LOWER, 8'h03);
      @(negedge mclk_i);
      chk("pad_oe before reset", 32'h01, {24'h0, pad_oe_o});
      @(posedge mclk_i);
      rstn_i <= 1'h0;
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'h1;
      @(negedge mclk_i);
      chk("ext_irq_line after reset", 32'h0, {24'h0, ext_irq_line_o});
      chk("pad_oe after reset", 32'h0, {24'h0, pad_oe_o});
      chk("irq after reset", 32'h0, {31'h0, irq_o});
      for (logic [11:0] i = `IDX_PIN_MODE_UPPER; i <= `IDX_IRQ_MASK; i++) begin
         rd(i, `REG_RESET);
      end
   endtask

   initial begin
      repeat (20) @(posedge mclk_i);
      rstn_i <= 1'h1;
      t_reset();
      t_modes();
      t_edges();
      t_irq();
      t_rerun();
      end_of_test();
   end
endmodule // port0_gpio_tb
